// file: fdc_central_model.sv
/*
 * Central link unit model: sends addressed command frames and collects
 * eight-character return frames.
 * Assumes callers enter its tasks just after a rising clock edge.
 */
`timescale 1ns/1ps
module fdc_central_model #(
  parameter int unsigned BIT = 16
) (
  input  wire logic clk,     // System clock
  output logic      rx_line, // Command line to the drop
  input  wire logic tx_line, // Return line from the drop
  input  wire logic tx_oe    // Drop drives return line
);
  logic line_in;

  // Released line rests at mark
  assign line_in = tx_oe ? tx_line : 1'b1;
  initial rx_line = 1'b1;

  // Start, data LSB first, even parity, stop at the line rate
  task automatic send_char(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ^b, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx_line <= f[i];
      repeat (BIT) @(posedge clk);
    end
  endtask

  // Address in byte 1, check as sum of bytes 1-3, optionally spoiled
  task automatic send_cmd(input logic [2:0] a, input logic [7:0] lo,
                          input logic [7:0] b2, input logic [7:0] b3,
                          input logic bad);
    logic [7:0] b1;
    logic [7:0] ck;
    b1 = {a, lo[4:0]};
    ck = b1 + b2 + b3 + {7'h0, bad};
    send_char(b1);
    send_char(b2);
    send_char(b3);
    send_char(ck);
  endtask

  // Collect eight characters, each waited for under a bound
  task automatic recv(output logic [63:0] r, output logic got,
                      output logic ok);
    int n;
    logic [10:0] f;
    r = '0;
    got = 1'b0;
    ok = 1'b1;
    for (int c = 0; c < 8; c++) begin
      n = 0;
      while (line_in !== 1'b0 && n < 600) begin
        @(posedge clk);
        n++;
      end
      if (n == 600) return;
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 11; i++) begin
        f[i] = line_in;
        if (i < 10) repeat (BIT) @(posedge clk);
      end
      ok = ok & (f[0] == 1'b0) & (f[10] == 1'b1) & (^f[9:1] == 1'b0);
      r[c*8 +: 8] = f[8:1];
    end
    repeat (BIT) @(posedge clk);
    got = 1'b1;
  endtask
endmodule

// file: fdc_drop.sv
/*
 * Field drop command monitor: decodes addressed command frames from the
 * central link unit, drives controller command outputs and answers with an
 * eight-byte return frame. Assumes synchronous inputs, one 200 MHz clock,
 * a separate receive and transmit pair of a multipoint four-wire line.
 */
// Contract
// [RULE1] Byte 1 bits 5-7 carry drop address
// [RULE2] Central puts target address in every block
// [RULE3] Byte 4 is check character over command
// [RULE4] Bad check: discard, keep last valid commands
// [RULE5] More than three bad frames: go off-line
// [RULE6] Hold-on-line also drives three companion outputs
// [RULE7] Byte 3 bits 0-5 drive ground-true spares
// [RULE8] Byte 3 bit 6 drives standby disable
// [RULE9] Byte 3 bit 7 drives phase omit
// [RULE10] Eight-byte return only after command frame
// [RULE11] Return byte 1 is phase greens
// [RULE12] Return byte 2 bits 0-1 spare inputs
// [RULE13] Return byte 2 bit 2 repair completed
// [RULE14] Bit 2 also power-fail latch, three seconds
// [RULE15] Return byte 2 bit 3 preemption
// [RULE16] Return byte 2 bit 4 standby flash
// [RULE17] Return byte 2 bit 5 any flash
// [RULE18] Return byte 2 bit 6 monitor tripped
// [RULE19] Return byte 2 bit 7 door open
// [RULE20] Return byte 3 is phase calls
// [RULE21] Return byte 4 is stop-line detector latches
// [RULE22] Character: start, eight data, parity, stop
// [RULE23] Command frame: three bytes plus check
// [RULE24] Line runs at 1312 bits per second
// [RULE25] Accept commands only at own address
// [RULE26] Check is modulo-256 sum of bytes 1-3

`timescale 1ns/1ps
module fdc_drop
  import fdc_pkg::*;
#(
  parameter int unsigned BIT_CYCLES     = FDC_BIT_CYCLES,
  parameter int unsigned GAP_CYCLES     = FDC_GAP_CYCLES,
  parameter int unsigned TURN_CYCLES    = FDC_TURN_CYCLES,
  parameter int unsigned PF_HOLD_CYCLES = FDC_PF_HOLD_CYCLES
) (
  input  wire logic        clk,          // System clock
  input  wire logic        sys_rst,      // Synchronous reset
  input  wire logic [2:0]  drop_addr,    // Preset drop address strap
  input  wire logic        rx_line,      // Command line from central
  output logic             tx_line,      // Return line to central
  output logic             tx_oe,        // Return line drive enable
  input  wire fdc_status_t ctl_status,   // Controller status inputs
  input  wire logic        power_fail,   // Power failure detected
  input  wire logic [7:0]  stop_det,     // Stop-line detector actuations
  output fdc_cmd_t         ctl_cmd,      // Commands to controller
  output logic             offline,      // Drop is off-line
  output logic [2:0]       bad_count     // Consecutive bad check count
);
  // Counter widths follow the timing counts, full or shortened
  localparam int unsigned GW  = $clog2(GAP_CYCLES + 1);
  localparam int unsigned TW  = $clog2(TURN_CYCLES + 1);
  localparam int unsigned PW  = $clog2(PF_HOLD_CYCLES + 1);

  typedef enum logic [1:0] {RS_IDLE, RS_TURN, RS_SEND} fdc_ret_state_t;

  // Receiver outputs
  logic [7:0] rx_data;
  logic       rx_valid;
  logic       rx_err;

  // Command frame assembly
  logic [7:0] cmd_buf [0:FDC_CMD_BYTES-2];
  logic [1:0] rx_idx;
  logic       frame_err;
  logic [GW-1:0] gap_cnt;
  logic       frame_done;
  logic       addr_ok;
  logic       sum_ok;
  logic [7:0] sum_calc;

  // Last valid command bytes
  logic [7:0] cmd_b1;
  logic [7:0] cmd_b3;

  // Return sequencing
  fdc_ret_state_t ret_state;
  logic [TW-1:0]  turn_cnt;
  logic [2:0]     ret_idx;
  logic [7:0]     ret_buf [0:FDC_RET_BYTES-1];
  logic [7:0]     tx_data;
  logic           tx_valid;
  logic           tx_ready;
  logic           ret_start;
  logic           ret_req;

  // Latches
  logic [7:0]     det_latch;
  logic           pf_latch;
  logic [PW-1:0]  pf_cnt;
  logic [7:0]     ret_byte2;
  logic [55:0]    ret_body;

  fdc_uart_rx #(
    .BIT_CYC (BIT_CYCLES)
  ) u_rx (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .rx_line  (rx_line),
    .rx_data  (rx_data),
    .rx_valid (rx_valid),
    .rx_err   (rx_err)
  );

  fdc_uart_tx #(
    .BIT_CYC (BIT_CYCLES)
  ) u_tx (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .tx_data  (tx_data),
    .tx_valid (tx_valid),
    .tx_ready (tx_ready),
    .tx_line  (tx_line),
    .tx_oe    (tx_oe)
  );

  // Frame completes on the fourth character [RULE23]
  assign frame_done = rx_valid && (rx_idx == 2'(FDC_CMD_BYTES - 1));
  // Address field compared with own strap [RULE1] [RULE25]
  assign addr_ok  = (cmd_buf[0][FDC_ADDR_MSB:FDC_ADDR_LSB] == drop_addr);
  // Check character is the byte sum of the command bytes [RULE3] [RULE26]
  assign sum_calc = fdc_sum8({40'h0, cmd_buf[2], cmd_buf[1], cmd_buf[0]});
  assign sum_ok   = (sum_calc == rx_data);
  // Answer any frame at this address free of character errors, good check or not [RULE10]
  assign ret_req  = frame_done && !frame_err && !rx_err && addr_ok;

  // Character index, byte errors and inter-character gap resync
  // A long silence drops a partial frame so the next one aligns
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_idx    <= 2'h0;
      frame_err <= 1'b0;
      gap_cnt   <= '0;
    end else if (rx_valid) begin
      gap_cnt   <= GW'(GAP_CYCLES);
      rx_idx    <= frame_done ? 2'h0 : rx_idx + 2'h1;
      frame_err <= frame_done ? 1'b0 : (frame_err | rx_err);
    end else if (gap_cnt != '0) begin
      gap_cnt <= gap_cnt - 1'b1;
      if (gap_cnt == GW'(1)) begin
        rx_idx    <= 2'h0;
        frame_err <= 1'b0;
      end
    end
  end

  // Command character storage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < FDC_CMD_BYTES - 1; i++) begin
        cmd_buf[i] <= 8'h00;
      end
    end else if (rx_valid && !frame_done) begin
      cmd_buf[rx_idx] <= rx_data;
    end
  end

  // Accept on good check, hold last valid data otherwise [RULE4] [RULE25]
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_b1 <= 8'h00;
      cmd_b3 <= 8'h00;
    end else if (ret_req && sum_ok) begin
      cmd_b1 <= cmd_buf[0];
      cmd_b3 <= cmd_buf[2];
    end
  end

  // Consecutive bad check count and off-line state [RULE5]
  // Count stops at three; the fourth bad frame trips off-line
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bad_count <= 3'h0;
      offline   <= 1'b0;
    end else if (ret_req && sum_ok) begin
      bad_count <= 3'h0;
      offline   <= 1'b0;
    end else if (ret_req) begin
      if (bad_count == FDC_BAD_LIMIT) begin
        offline <= 1'b1;
      end else begin
        bad_count <= bad_count + 3'h1;
      end
    end
  end

  // Controller outputs, released while off-line
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctl_cmd <= FDC_CMD_RELEASED;
    end else if (offline) begin
      ctl_cmd <= FDC_CMD_RELEASED;                        // [RULE5]
    end else begin
      ctl_cmd.hold_on_line    <= cmd_b1[FDC_HOL_BIT];
      ctl_cmd.walk_rest_mod   <= cmd_b1[FDC_HOL_BIT];     // [RULE6]
      ctl_cmd.inhibit_max     <= cmd_b1[FDC_HOL_BIT];     // [RULE6]
      ctl_cmd.coord_hold_en   <= cmd_b1[FDC_HOL_BIT];     // [RULE6]
      ctl_cmd.standby_disable <= cmd_b3[FDC_STBY_DIS_BIT]; // [RULE8]
      ctl_cmd.phase_omit      <= cmd_b3[FDC_OMIT_BIT];    // [RULE9]
      ctl_cmd.spare_out_n     <= ~cmd_b3[FDC_SPARE_W-1:0]; // [RULE7]
    end
  end

  // Stop-line detector latches, set wins over clear [RULE21]
  // An actuation in the clearing cycle waits for the next frame
  generate
    for (genvar d = 0; d < 8; d++) begin : g_det
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          det_latch[d] <= 1'b0;
        end else if (stop_det[d]) begin
          det_latch[d] <= 1'b1;
        end else if (ret_start) begin
          det_latch[d] <= 1'b0;
        end
      end
    end
  endgenerate

  // Power-fail latch, cleared after three seconds of sending [RULE14]
  // Only sending time counts, so a quiet line keeps the flag up
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pf_latch <= 1'b0;
      pf_cnt   <= '0;
    end else if (power_fail) begin
      pf_latch <= 1'b1;
      pf_cnt   <= '0;
    end else if (pf_latch && tx_oe) begin
      if (pf_cnt == PW'(PF_HOLD_CYCLES - 1)) begin
        pf_latch <= 1'b0;
        pf_cnt   <= '0;
      end else begin
        pf_cnt <= pf_cnt + 1'b1;
      end
    end
  end

  // Return status byte 2
  always_comb begin
    ret_byte2 = 8'h00;
    ret_byte2[FDC_R2_SPARE0]   = ~ctl_status.spare_in_n[0];    // [RULE12]
    ret_byte2[FDC_R2_SPARE1]   = ~ctl_status.spare_in_n[1];    // [RULE12]
    ret_byte2[FDC_R2_REPAIR]   = ctl_status.repair_done
                                 | pf_latch;            // [RULE13] [RULE14]
    ret_byte2[FDC_R2_PREEMPT]  = ctl_status.preemption_flag;   // [RULE15]
    ret_byte2[FDC_R2_SB_FLASH] = ctl_status.standby_flash;     // [RULE16]
    ret_byte2[FDC_R2_FLASH]    = ctl_status.flash_any;         // [RULE17]
    ret_byte2[FDC_R2_CM_TRIP]  = ctl_status.cm_tripped;        // [RULE18]
    ret_byte2[FDC_R2_DOOR]     = ctl_status.door_open;         // [RULE19]
  end

  // Bytes 1 to 7 in transmit order, unused bytes zero [RULE11] [RULE20]
  assign ret_body = {24'h0, det_latch, ctl_status.phase_call, ret_byte2,
                     ctl_status.phase_green_status};

  // Turnaround wait then eight characters in order [RULE10]
  // A frame heard mid-reply updates outputs but earns no reply
  assign ret_start = (ret_state == RS_TURN) && (turn_cnt == '0);
  assign tx_valid  = (ret_state == RS_SEND);
  assign tx_data   = ret_buf[ret_idx];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ret_state <= RS_IDLE;
      turn_cnt  <= '0;
      ret_idx   <= 3'h0;
    end else begin
      case (ret_state)
        RS_IDLE: begin
          if (ret_req) begin
            ret_state <= RS_TURN;
            turn_cnt  <= TW'(TURN_CYCLES - 1);
          end
        end
        RS_TURN: begin
          if (turn_cnt != '0) begin
            turn_cnt <= turn_cnt - 1'b1;
          end else begin
            ret_state <= RS_SEND;
            ret_idx   <= 3'h0;
          end
        end
        RS_SEND: begin
          if (tx_ready) begin
            ret_idx <= ret_idx + 3'h1;
            if (ret_idx == 3'(FDC_RET_BYTES - 1)) begin
              ret_state <= RS_IDLE;
            end
          end
        end
        default: ret_state <= RS_IDLE;
      endcase
    end
  end

  // Snapshot of the return frame and its trailing check character
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < FDC_RET_BYTES; i++) begin
        ret_buf[i] <= 8'h00;
      end
    end else if (ret_start) begin
      for (int i = 0; i < FDC_RET_BYTES - 1; i++) begin
        ret_buf[i] <= ret_body[i*8 +: 8];
      end
      ret_buf[FDC_RET_BYTES-1] <= fdc_sum8({8'h00, ret_body});
    end
  end

endmodule

// file: fdc_drop_props.sv
/*
 * Concurrent checks on the field drop ports: off-line release, hold-on-line
 * companions, bad-frame counting and return line framing.
 * Assumes it is bound to fdc_drop and sees only that module's ports.
 */
`timescale 1ns/1ps
module fdc_drop_chk
  import fdc_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = FDC_BIT_CYCLES
) (
  input wire logic        clk,        // System clock
  input wire logic        sys_rst,    // Synchronous reset
  input wire logic [2:0]  drop_addr,  // Own address strap
  input wire logic        rx_line,    // Command line
  input wire logic        tx_line,    // Return line
  input wire logic        tx_oe,      // Return drive enable
  input wire fdc_status_t ctl_status, // Controller status
  input wire logic        power_fail, // Power failure
  input wire logic [7:0]  stop_det,   // Detector actuations
  input wire fdc_cmd_t    ctl_cmd,    // Commands out
  input wire logic        offline,    // Off-line flag
  input wire logic [2:0]  bad_count   // Bad frame count
);
  localparam int unsigned OE_MIN = 88 * BIT_CYCLES;
  logic [31:0] oe_cnt;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Cycles the return line has been driven
  always_ff @(posedge clk) begin
    if (sys_rst || !tx_oe) begin
      oe_cnt <= 32'h0;
    end else begin
      oe_cnt <= oe_cnt + 32'h1;
    end
  end

  chk_offline_released: assert property (
    offline |=> ctl_cmd == FDC_CMD_RELEASED)
    else $error("commands not released while off-line");
  chk_hold_companions: assert property (
    ctl_cmd.hold_on_line |->
      ctl_cmd.walk_rest_mod && ctl_cmd.inhibit_max && ctl_cmd.coord_hold_en)
    else $error("hold-on-line without companion outputs");
  chk_companion_source: assert property (
    (ctl_cmd.walk_rest_mod || ctl_cmd.inhibit_max || ctl_cmd.coord_hold_en)
      |-> ctl_cmd.hold_on_line)
    else $error("companion output without hold-on-line");
  chk_bad_limit: assert property (
    bad_count <= 3'h3)
    else $error("bad frame count above three");
  chk_offline_entry: assert property (
    $rose(offline) |-> $past(bad_count) == 3'h3)
    else $error("off-line entered before four bad frames");
  chk_bad_step: assert property (
    !$stable(bad_count) |->
      (bad_count == $past(bad_count) + 3'h1) || (bad_count == 3'h0))
    else $error("bad frame count jumped");
  chk_idle_mark: assert property (
    !tx_oe |-> tx_line)
    else $error("return line not idle high while released");
  chk_start_bit: assert property (
    $rose(tx_oe) |-> !tx_line [*4])
    else $error("return character without start bit");
  chk_frame_length: assert property (
    $fell(tx_oe) |-> oe_cnt == OE_MIN + 8)
    else $error("return frame not eight characters long");
endmodule

bind fdc_drop fdc_drop_chk #(.BIT_CYCLES(BIT_CYCLES)) fdc_drop_chk_inst (
  .clk(clk), .sys_rst(sys_rst), .drop_addr(drop_addr), .rx_line(rx_line),
  .tx_line(tx_line), .tx_oe(tx_oe), .ctl_status(ctl_status),
  .power_fail(power_fail), .stop_det(stop_det), .ctl_cmd(ctl_cmd),
  .offline(offline), .bad_count(bad_count));

// file: fdc_pkg.sv
/*
 * Shared constants, types and helpers for the field drop command monitor.
 * Assumes a single 200 MHz system clock and a synchronous active-high reset.
 */
package fdc_pkg;

  // Clock and serial timing
  localparam int unsigned FDC_CLK_HZ       = 200_000_000;
  localparam int unsigned FDC_BIT_RATE     = 1312;
  localparam int unsigned FDC_BIT_CYCLES   = FDC_CLK_HZ / FDC_BIT_RATE;
  localparam int unsigned FDC_CHAR_BITS    = 11;
  localparam int unsigned FDC_GAP_CHARS    = 2;
  localparam int unsigned FDC_GAP_CYCLES   =
    FDC_BIT_CYCLES * FDC_CHAR_BITS * FDC_GAP_CHARS;
  localparam int unsigned FDC_TURN_MS      = 10;
  localparam int unsigned FDC_TURN_CYCLES  =
    (FDC_CLK_HZ / 1000) * FDC_TURN_MS;
  localparam int unsigned FDC_PF_HOLD_S    = 3;
  localparam int unsigned FDC_PF_HOLD_CYCLES = FDC_CLK_HZ * FDC_PF_HOLD_S;

  // Frame sizes and error limit
  localparam int unsigned FDC_CMD_BYTES    = 4;
  localparam int unsigned FDC_RET_BYTES    = 8;
  localparam logic [2:0]  FDC_BAD_LIMIT    = 3'h3;

  // Command byte 1 fields
  localparam int unsigned FDC_ADDR_MSB     = 7;
  localparam int unsigned FDC_ADDR_LSB     = 5;
  localparam int unsigned FDC_HOL_BIT      = 3;
  // Command byte 3 fields
  localparam int unsigned FDC_SPARE_W      = 6;
  localparam int unsigned FDC_STBY_DIS_BIT = 6;
  localparam int unsigned FDC_OMIT_BIT     = 7;

  // Return byte 2 field positions
  localparam int unsigned FDC_R2_SPARE0    = 0;
  localparam int unsigned FDC_R2_SPARE1    = 1;
  localparam int unsigned FDC_R2_REPAIR    = 2;
  localparam int unsigned FDC_R2_PREEMPT   = 3;
  localparam int unsigned FDC_R2_SB_FLASH  = 4;
  localparam int unsigned FDC_R2_FLASH     = 5;
  localparam int unsigned FDC_R2_CM_TRIP   = 6;
  localparam int unsigned FDC_R2_DOOR      = 7;

  // Controller status inputs, all active high except ground-true spares
  typedef struct packed {
    logic [7:0] phase_green_status;
    logic [7:0] phase_call;
    logic [1:0] spare_in_n;
    logic       repair_done;
    logic       preemption_flag;
    logic       standby_flash;
    logic       flash_any;
    logic       cm_tripped;
    logic       door_open;
  } fdc_status_t;

  // Controller command outputs
  typedef struct packed {
    logic                   hold_on_line;
    logic                   walk_rest_mod;
    logic                   inhibit_max;
    logic                   coord_hold_en;
    logic                   standby_disable;
    logic                   phase_omit;
    logic [FDC_SPARE_W-1:0] spare_out_n;
  } fdc_cmd_t;

  localparam fdc_cmd_t FDC_CMD_RELEASED = '{
    hold_on_line: 1'b0, walk_rest_mod: 1'b0, inhibit_max: 1'b0,
    coord_hold_en: 1'b0, standby_disable: 1'b0, phase_omit: 1'b0,
    spare_out_n: {FDC_SPARE_W{1'b1}}};

  // Modulo-256 sum of eight packed bytes
  function automatic logic [7:0] fdc_sum8(input logic [63:0] bytes);
    logic [7:0] acc;
    acc = 8'h00;
    for (int i = 0; i < 8; i++) begin
      acc = acc + bytes[i*8 +: 8];
    end
    return acc;
  endfunction

endpackage

// file: fdc_uart_rx.sv
/*
 * Serial character receiver: start, eight data bits LSB first, even
 * parity, stop. Assumes the line input is already synchronous and idles high.
 */
`timescale 1ns/1ps
module fdc_uart_rx
  import fdc_pkg::*;
#(
  parameter int unsigned BIT_CYC = FDC_BIT_CYCLES
) (
  input  wire logic       clk,       // System clock
  input  wire logic       sys_rst,   // Synchronous reset
  input  wire logic       rx_line,   // Serial line, idle high
  output logic [7:0]      rx_data,   // Received byte
  output logic            rx_valid,  // One-cycle byte strobe
  output logic            rx_err     // Parity or framing error, with strobe
);
  localparam int unsigned CW = $clog2(BIT_CYC + 1);

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
    fdc_rx_state_t;

  fdc_rx_state_t state;
  logic [CW-1:0] cnt;
  logic [2:0]    idx;
  logic [7:0]    shreg;
  logic          par_bad;

  // Bit-timing state machine, sampling at bit centres [RULE22] [RULE24]
  always_ff @(posedge clk) begin
    rx_valid <= 1'b0;
    if (sys_rst) begin
      state   <= RX_IDLE;
      cnt     <= '0;
      idx     <= 3'h0;
      shreg   <= 8'h00;
      par_bad <= 1'b0;
      rx_data <= 8'h00;
      rx_err  <= 1'b0;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end else begin
      case (state)
        RX_IDLE: begin
          if (!rx_line) begin
            state <= RX_START;
            cnt   <= CW'(BIT_CYC / 2);
          end
        end
        RX_START: begin
          state <= rx_line ? RX_IDLE : RX_DATA;
          cnt   <= CW'(BIT_CYC - 1);
          idx   <= 3'h0;
        end
        RX_DATA: begin
          shreg <= {rx_line, shreg[7:1]};
          cnt   <= CW'(BIT_CYC - 1);
          idx   <= idx + 3'h1;
          if (idx == 3'h7) begin
            state <= RX_PAR;
          end
        end
        RX_PAR: begin
          par_bad <= ^{shreg, rx_line};
          cnt     <= CW'(BIT_CYC - 1);
          state   <= RX_STOP;
        end
        RX_STOP: begin
          rx_data  <= shreg;
          rx_err   <= par_bad | ~rx_line;
          rx_valid <= 1'b1;
          state    <= RX_IDLE;
        end
        default: state <= RX_IDLE;
      endcase
    end
  end

endmodule

// file: fdc_uart_tx.sv
/*
 * Serial character transmitter: start, eight data bits LSB first, even
 * parity, stop. Drives the line and its enable only while sending.
 */
`timescale 1ns/1ps
module fdc_uart_tx
  import fdc_pkg::*;
#(
  parameter int unsigned BIT_CYC = FDC_BIT_CYCLES
) (
  input  wire logic       clk,       // System clock
  input  wire logic       sys_rst,   // Synchronous reset
  input  wire logic [7:0] tx_data,   // Byte to send
  input  wire logic       tx_valid,  // Byte offered
  output logic            tx_ready,  // Transmitter idle, byte taken
  output logic            tx_line,   // Serial line out, idle high
  output logic            tx_oe      // High while driving the line
);
  localparam int unsigned CW = $clog2(BIT_CYC + 1);

  logic [CW-1:0] cnt;
  logic [3:0]    left;
  logic [10:0]   shreg;

  assign tx_ready = (left == 4'h0);
  assign tx_line  = shreg[0];

  // Shift out start, data, parity, stop [RULE22] [RULE24]
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt   <= '0;
      left  <= 4'h0;
      shreg <= 11'h7ff;
      tx_oe <= 1'b0;
    end else if (tx_ready) begin
      if (tx_valid) begin
        shreg <= {1'b1, ^tx_data, tx_data, 1'b0};
        left  <= 4'(FDC_CHAR_BITS);
        cnt   <= CW'(BIT_CYC - 1);
        tx_oe <= 1'b1;
      end else begin
        tx_oe <= 1'b0;
      end
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end else begin
      shreg <= {1'b1, shreg[10:1]};
      left  <= left - 4'h1;
      cnt   <= CW'(BIT_CYC - 1);
    end
  end

endmodule

// file: testbench.sv
/*
 * Self-checking bench for the field drop: command decoding, bad-check
 * handling, off-line entry and recovery, and return frame contents.
 * Assumes shortened bit, gap, turnaround and power-fail hold counts.
 */
`timescale 1ns/1ps
module testbench;
  import fdc_pkg::*;
  localparam int unsigned BIT = 16;
  logic        clk;
  logic        sys_rst;
  logic [2:0]  drop_addr;
  logic        rx_line;
  logic        tx_line;
  logic        tx_oe;
  fdc_status_t ctl_status;
  logic        power_fail;
  logic [7:0]  stop_det;
  fdc_cmd_t    ctl_cmd;
  logic        offline;
  logic [2:0]  bad_count;
  int          failures;
  int          compares;
  logic [63:0] ret;
  logic [63:0] e;
  logic        got;
  logic        ok;
  fdc_cmd_t    last;
  logic [7:0]  lo_tab [3];
  logic [7:0]  b3_tab [3];

  fdc_drop #(.BIT_CYCLES(BIT), .GAP_CYCLES(BIT * 22), .TURN_CYCLES(20),
             .PF_HOLD_CYCLES(500)) fdc_drop_inst (
    .clk(clk), .sys_rst(sys_rst), .drop_addr(drop_addr), .rx_line(rx_line),
    .tx_line(tx_line), .tx_oe(tx_oe), .ctl_status(ctl_status),
    .power_fail(power_fail), .stop_det(stop_det), .ctl_cmd(ctl_cmd),
    .offline(offline), .bad_count(bad_count));

  fdc_central_model #(.BIT(BIT)) fdc_central_model_inst (
    .clk(clk), .rx_line(rx_line), .tx_line(tx_line), .tx_oe(tx_oe));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Commands expected from byte 1 low bits and byte 3
  function automatic fdc_cmd_t cmd_exp(input logic [7:0] lo,
                                       input logic [7:0] b3);
    fdc_cmd_t c;
    c.hold_on_line = lo[3];
    c.walk_rest_mod = lo[3];
    c.inhibit_max = lo[3];
    c.coord_hold_en = lo[3];
    c.standby_disable = b3[6];
    c.phase_omit = b3[7];
    c.spare_out_n = ~b3[5:0];
    return c;
  endfunction

  // Return frame expected from status, power-fail latch and detectors
  function automatic logic [63:0] ret_exp(input fdc_status_t s,
                                          input logic pf,
                                          input logic [7:0] det);
    logic [63:0] v;
    logic [7:0]  sum;
    v = {32'h0, det, s.phase_call, s.door_open, s.cm_tripped, s.flash_any,
         s.standby_flash, s.preemption_flag, s.repair_done | pf,
         ~s.spare_in_n, s.phase_green_status};
    sum = 8'h00;
    for (int i = 0; i < 7; i++) begin
      sum = sum + v[i*8 +: 8];
    end
    v[63:56] = sum;
    return v;
  endfunction

  // One command frame and, where expected, its return frame
  task automatic xfer(input logic [2:0] a, input logic [7:0] lo,
                      input logic [7:0] b3, input logic bad,
                      input logic want);
    fdc_central_model_inst.send_cmd(a, lo, 8'h5a, b3, bad);
    fdc_central_model_inst.recv(ret, got, ok);
    check(64'(got), 64'(want));
    check(64'(ok), 64'h1);
    if (want && !got) finish_test();
  endtask

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    drop_addr = 3'h5;
    power_fail = 1'b0;
    stop_det = 8'h00;
    ctl_status = {8'ha5, 8'h3c, 2'b10, 6'b010101};
    failures = 0;
    compares = 0;
    lo_tab = '{8'h08, 8'h00, 8'h00};
    b3_tab = '{8'h3f, 8'hd5, 8'h2a};
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check(64'(ctl_cmd), 64'(FDC_CMD_RELEASED));
    check(64'(offline), 64'h0);
    check(64'(bad_count), 64'h0);
    // Power failure and detector pulses before the first poll
    power_fail <= 1'b1;
    stop_det <= 8'h81;
    @(posedge clk);
    power_fail <= 1'b0;
    stop_det <= 8'h00;
    // Three polls: latches once, then cleared, then repair input
    for (int i = 0; i < 3; i++) begin
      if (i == 1) ctl_status <= ctl_status ^ 24'hffffdf;
      if (i == 2) ctl_status.repair_done <= 1'b1;
      xfer(3'h5, lo_tab[i], b3_tab[i], 1'b0, 1'b1);
      last = cmd_exp(lo_tab[i], b3_tab[i]);
      check(64'(ctl_cmd), 64'(last));
      e = ret_exp(ctl_status, i == 0, i == 0 ? 8'h81 : 8'h00);
      check(64'(ret[7:0]), 64'(e[7:0]));
      check(64'(ret[10:8]), 64'(e[10:8]));
      check(64'(ret[13:11]), 64'(e[13:11]));
      check(64'(ret[15:14]), 64'(e[15:14]));
      check(64'(ret[23:16]), 64'(e[23:16]));
      check(64'(ret[31:24]), 64'(e[31:24]));
      check(64'(ret[63:32]), 64'(e[63:32]));
    end
    // Frame for another drop is ignored
    xfer(3'h2, 8'h08, 8'h00, 1'b0, 1'b0);
    check(64'(ctl_cmd), 64'(last));
    // Four bad checks in a row: hold, then off-line
    for (int k = 1; k < 5; k++) begin
      xfer(3'h5, 8'h00, 8'h3f, 1'b1, 1'b1);
      if (k < 4) check(64'(bad_count), 64'(k));
      check(64'(offline), 64'(k == 4));
      if (k < 4) check(64'(ctl_cmd), 64'(last));
      else check(64'(ctl_cmd), 64'(FDC_CMD_RELEASED));
    end
    // Good frame brings the drop back on line
    xfer(3'h5, 8'h08, 8'h80, 1'b0, 1'b1);
    check(64'(offline), 64'h0);
    check(64'(bad_count), 64'h0);
    check(64'(ctl_cmd), 64'(cmd_exp(8'h08, 8'h80)));
    // Address zero boundary
    drop_addr <= 3'h0;
    @(posedge clk);
    xfer(3'h0, 8'h00, 8'h40, 1'b0, 1'b1);
    check(64'(ctl_cmd), 64'(cmd_exp(8'h00, 8'h40)));
    finish_test();
  end
endmodule
